// ===== logic/pmsc_map.svh
// command codes, field positions, reset values and limits of the status and mfr command bank
`ifndef PMSC_MAP_SVH
`define PMSC_MAP_SVH
// ****************************************
// command codes
// ****************************************
`define PMSC_CMD_IN_STATUS   8'h7c
`define PMSC_CMD_TEMP_STATUS 8'h7d
`define PMSC_CMD_LINK_STATUS 8'h7e
`define PMSC_CMD_RD_VIN      8'h88
`define PMSC_CMD_RD_VOUT     8'h8b
`define PMSC_CMD_RD_IOUT     8'h8c
`define PMSC_CMD_RD_TEMP     8'h8d
`define PMSC_CMD_REVISION    8'h98
`define PMSC_CMD_MOD_TYPE    8'hd0
`define PMSC_CMD_VO_GAIN     8'hd1
`define PMSC_CMD_VO_OFF      8'hd2
`define PMSC_CMD_VI_GAIN     8'hd3
`define PMSC_CMD_VI_OFF      8'hd4
`define PMSC_CMD_IO_GAIN     8'hd6
`define PMSC_CMD_IO_OFF      8'hd7
`define PMSC_CMD_FW_REV      8'hdb
`define PMSC_CMD_ARA_CFG     8'he0
`define PMSC_CMD_PG_POL      8'he2
`define PMSC_CMD_SERIAL      8'hf0
// ****************************************
// fields and values
// ****************************************
`define PMSC_IN_MASK         8'h98
`define PMSC_TEMP_MASK       8'hc0
`define PMSC_LINK_MASK       8'he0
`define PMSC_BIT_BAD_CMD     7
`define PMSC_BIT_BAD_DATA    6
`define PMSC_BIT_PEC         5
`define PMSC_REV_VALUE       8'h42
`define PMSC_WPE_BIT         1
`define PMSC_ARA_BIT         4
`define PMSC_PGPOL_BIT       0
`define PMSC_WPE_RST         1'b1
`define PMSC_ARA_RST         1'b0
`define PMSC_PGPOL_RST       1'b1
`define PMSC_GAIN_RST        16'h2000
`define PMSC_GAIN_MIN        16'h1999
`define PMSC_GAIN_MAX        16'h2666
`define PMSC_EXP_M12         5'h14
`define PMSC_EXP_M3          5'h1d
`define PMSC_SN_BYTES        12
`endif

// ===== logic/pmsc_pkg.sv
// types shared by the status and mfr command bank
`default_nettype none
package pmsc_pkg;
  // condition levels from the power stage
  typedef struct packed {
    logic vin_ov;
    logic vin_uv;
    logic vin_low_off;
    logic overtemperature_fault;
    logic overtemperature_warning;
    logic power_good_output;
  } pmsc_cond_t;
  // sticky status bytes
  typedef struct packed {
    logic [7:0] in_st;
    logic [7:0] temp_st;
    logic [7:0] link_st;
  } pmsc_stat_t;
  // writable configuration
  typedef struct packed {
    logic        write_protect_enable;
    logic        ara;
    logic        pg_pol;
    logic [15:0] vo_gain;
    logic [15:0] vo_off;
    logic [15:0] vi_gain;
    logic [15:0] vi_off;
    logic [15:0] io_gain;
    logic [15:0] io_off;
  } pmsc_cfg_t;
  // answer to one command
  typedef struct packed {
    logic        valid;
    logic        refused;
    logic [15:0] data;
  } pmsc_rsp_t;
endpackage : pmsc_pkg
`default_nettype wire

// ===== logic/pmsc_regs.sv
// command register bank: status bytes, telemetry, revision and mfr commands
`timescale 1ns/100ps
`default_nettype none
`include "pmsc_map.svh"
module pmsc_regs
  import pmsc_pkg::*;
#(
  parameter logic [5:0]  MODULE_CODE = 6'h15,    // arbitrary value
  parameter logic [15:0] FW_REV      = 16'h1101,
  parameter logic [15:0] IO_GAIN_RST = `PMSC_GAIN_RST,
  parameter logic [15:0] VO_OFF_RST  = 16'ha000,
  parameter logic [15:0] VI_OFF_RST  = 16'he800,
  parameter logic [15:0] IO_OFF_RST  = 16'he800
) (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_CLK_EN,
  input  wire logic        I_CMD_VALID,
  input  wire logic        I_CMD_WRITE,
  input  wire logic [7:0]  I_CMD_CODE,
  input  wire logic [15:0] I_CMD_WDATA,
  input  wire logic [3:0]  I_CMD_BYTE_IDX,
  input  wire logic        I_PEC_ERROR,
  input  wire logic        I_VIN_OV,
  input  wire logic        I_VIN_UV,
  input  wire logic        I_VIN_LOW_OFF,
  input  wire logic        I_OVERTEMPERATURE_FAULT,
  input  wire logic        I_OVERTEMPERATURE_WARNING,
  input  wire logic        I_POWER_IS_GOOD,
  input  wire logic        I_ALERT_ACTIVE,
  input  wire logic [15:0] I_VIN_READING,
  input  wire logic [15:0] I_VOUT_READING,
  input  wire logic [15:0] I_IOUT_READING,
  input  wire logic [15:0] I_TEMP_READING,
  output logic             O_RSP_VALID,
  output logic             O_RSP_REFUSED,
  output logic [15:0]      O_RSP_DATA,
  output logic             O_ARA_ONLY,
  output logic             O_POWER_GOOD_OUTPUT,
  output logic             O_WRITE_PROTECT
);
  localparam int SN = `PMSC_SN_BYTES;

  // ****************************************
  // pin synchronisers
  // ****************************************
  pmsc_cond_t cond_m_q;
  pmsc_cond_t cond_q;
  pmsc_cond_t cond_pin;
  assign cond_pin = '{I_VIN_OV, I_VIN_UV, I_VIN_LOW_OFF, I_OVERTEMPERATURE_FAULT, I_OVERTEMPERATURE_WARNING, I_POWER_IS_GOOD};

  // first stage is read only by the second
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cond_m_q <= '0;
      cond_q   <= '0;
    end else if (I_CLK_EN) begin
      cond_m_q <= cond_pin;
      cond_q   <= cond_m_q;
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  pmsc_stat_t stat_q, stat_d;
  pmsc_cfg_t  cfg_q, cfg_d;
  pmsc_rsp_t  rsp_q, rsp_d;
  logic [7:0] sn_q [SN];
  logic [7:0] sn_d [SN];
  logic        known, ro, prot, data_ok, is_blk, idx_ok;
  logic [15:0] rd_word;
  logic        wr, accept, bad_cmd, bad_data;

  assign idx_ok = I_CMD_BYTE_IDX < 4'(SN);
  assign wr     = I_CMD_VALID & I_CMD_WRITE;

  // classify the command and build its read word
  always_comb begin
    known   = 1'b1;
    ro      = 1'b0;
    prot    = 1'b0;
    data_ok = 1'b1;
    is_blk  = 1'b0;
    rd_word = 16'h0000;
    case (I_CMD_CODE)
      `PMSC_CMD_IN_STATUS:   rd_word = {8'h00, stat_q.in_st};
      `PMSC_CMD_TEMP_STATUS: rd_word = {8'h00, stat_q.temp_st};
      `PMSC_CMD_LINK_STATUS: rd_word = {8'h00, stat_q.link_st};
      `PMSC_CMD_RD_VIN: begin
        ro      = 1'b1;
        rd_word = I_VIN_READING;
      end
      `PMSC_CMD_RD_VOUT: begin
        ro      = 1'b1;
        rd_word = I_VOUT_READING;
      end
      `PMSC_CMD_RD_IOUT: begin
        ro      = 1'b1;
        rd_word = I_IOUT_READING;
      end
      `PMSC_CMD_RD_TEMP: begin
        ro      = 1'b1;
        rd_word = I_TEMP_READING;
      end
      `PMSC_CMD_REVISION: begin
        ro      = 1'b1;
        rd_word = {8'h00, `PMSC_REV_VALUE};
      end
      `PMSC_CMD_MOD_TYPE: rd_word = {8'h00, MODULE_CODE, cfg_q.write_protect_enable, 1'b0};
      `PMSC_CMD_VO_GAIN, `PMSC_CMD_VI_GAIN, `PMSC_CMD_IO_GAIN: begin
        prot    = 1'b1;
        data_ok = (I_CMD_WDATA >= `PMSC_GAIN_MIN) && (I_CMD_WDATA <= `PMSC_GAIN_MAX);
        rd_word = (I_CMD_CODE == `PMSC_CMD_VO_GAIN) ? cfg_q.vo_gain :
                  (I_CMD_CODE == `PMSC_CMD_VI_GAIN) ? cfg_q.vi_gain : cfg_q.io_gain;
      end
      `PMSC_CMD_VO_OFF: begin
        prot    = 1'b1;
        data_ok = I_CMD_WDATA[15:11] == `PMSC_EXP_M12;
        rd_word = cfg_q.vo_off;
      end
      `PMSC_CMD_VI_OFF, `PMSC_CMD_IO_OFF: begin
        prot    = 1'b1;
        data_ok = I_CMD_WDATA[15:11] == `PMSC_EXP_M3;
        rd_word = (I_CMD_CODE == `PMSC_CMD_VI_OFF) ? cfg_q.vi_off : cfg_q.io_off;
      end
      `PMSC_CMD_FW_REV: begin
        ro      = 1'b1;
        rd_word = FW_REV;
      end
      `PMSC_CMD_ARA_CFG: rd_word = {11'h000, cfg_q.ara, 4'h0};
      `PMSC_CMD_PG_POL:  rd_word = {15'h0000, cfg_q.pg_pol};
      `PMSC_CMD_SERIAL: begin
        prot    = 1'b1;
        is_blk  = 1'b1;
        data_ok = idx_ok;
        rd_word = idx_ok ? {8'h00, sn_q[I_CMD_BYTE_IDX]} : 16'h0000;
      end
      default: known = 1'b0;
    endcase
  end

  // a protected write is refused whole while the protect bit is set
  assign accept   = wr & known & ~ro & data_ok & ~(prot & cfg_q.write_protect_enable);
  assign bad_cmd  = I_CMD_VALID & (~known | (wr & ro));
  assign bad_data = I_CMD_VALID & known & ~(wr & ro) & ~data_ok & (I_CMD_WRITE | is_blk)
                  | wr & known & ~ro & data_ok & prot & cfg_q.write_protect_enable;

  // ****************************************
  // sticky status
  // ****************************************
  logic [7:0] in_set, temp_set, link_set, in_clr, temp_clr, link_clr;

  // hardware set is ored in after the host clear, so a set in the clear cycle survives
  always_comb begin
    in_set   = {cond_q.vin_ov, 2'b00, cond_q.vin_uv, cond_q.vin_low_off, 3'b000};
    temp_set = {cond_q.overtemperature_fault, cond_q.overtemperature_warning, 6'h00};
    link_set = {bad_cmd, bad_data, I_PEC_ERROR, 5'h00};
    in_clr   = (accept && I_CMD_CODE == `PMSC_CMD_IN_STATUS)   ? I_CMD_WDATA[7:0] : 8'h00;
    temp_clr = (accept && I_CMD_CODE == `PMSC_CMD_TEMP_STATUS) ? I_CMD_WDATA[7:0] : 8'h00;
    link_clr = (accept && I_CMD_CODE == `PMSC_CMD_LINK_STATUS) ? I_CMD_WDATA[7:0] : 8'h00;
    stat_d.in_st   = ((stat_q.in_st & ~in_clr) | in_set) & `PMSC_IN_MASK;
    stat_d.temp_st = ((stat_q.temp_st & ~temp_clr) | temp_set) & `PMSC_TEMP_MASK;
    stat_d.link_st = ((stat_q.link_st & ~link_clr) | link_set) & `PMSC_LINK_MASK;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      stat_q <= '0;
    end else if (I_CLK_EN) begin
      stat_q <= stat_d;
    end
  end

  // ****************************************
  // configuration
  // ****************************************
  // calibration words are held in flops; persistence is up to the store logic outside
  always_comb begin
    cfg_d = cfg_q;
    if (accept) begin
      case (I_CMD_CODE)
        `PMSC_CMD_MOD_TYPE: cfg_d.write_protect_enable     = I_CMD_WDATA[`PMSC_WPE_BIT];
        `PMSC_CMD_VO_GAIN:  cfg_d.vo_gain = I_CMD_WDATA;
        `PMSC_CMD_VO_OFF:   cfg_d.vo_off  = I_CMD_WDATA;
        `PMSC_CMD_VI_GAIN:  cfg_d.vi_gain = I_CMD_WDATA;
        `PMSC_CMD_VI_OFF:   cfg_d.vi_off  = I_CMD_WDATA;
        `PMSC_CMD_IO_GAIN:  cfg_d.io_gain = I_CMD_WDATA;
        `PMSC_CMD_IO_OFF:   cfg_d.io_off  = I_CMD_WDATA;
        `PMSC_CMD_ARA_CFG:  cfg_d.ara     = I_CMD_WDATA[`PMSC_ARA_BIT];
        `PMSC_CMD_PG_POL:   cfg_d.pg_pol  = I_CMD_WDATA[`PMSC_PGPOL_BIT];
        default: cfg_d = cfg_q;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cfg_q <= '{`PMSC_WPE_RST, `PMSC_ARA_RST, `PMSC_PGPOL_RST, `PMSC_GAIN_RST, VO_OFF_RST,
                 `PMSC_GAIN_RST, VI_OFF_RST, IO_GAIN_RST, IO_OFF_RST};
    end else if (I_CLK_EN) begin
      cfg_q <= cfg_d;
    end
  end

  // ****************************************
  // serial record, one byte per write
  // ****************************************
  for (genvar g = 0; g < SN; g++) begin : g_sn
    always_comb begin
      sn_d[g] = (accept && is_blk && I_CMD_BYTE_IDX == 4'(g)) ? I_CMD_WDATA[7:0] : sn_q[g];
    end
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
        sn_q[g] <= 8'h00;
      end else if (I_CLK_EN) begin
        sn_q[g] <= sn_d[g];
      end
    end
  end

  // ****************************************
  // answer and pins
  // ****************************************
  logic pg_pin_q, pg_pin_d;

  // answer one cycle after the command; writes answer zero data
  always_comb begin
    rsp_d.valid   = I_CMD_VALID;
    rsp_d.refused = I_CMD_VALID & (bad_cmd | bad_data);
    rsp_d.data    = (I_CMD_VALID && !I_CMD_WRITE && known) ? rd_word : 16'h0000;
    pg_pin_d      = ~(cond_q.power_good_output ^ cfg_q.pg_pol);
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rsp_q    <= '0;
      pg_pin_q <= 1'b0;
    end else if (I_CLK_EN) begin
      rsp_q    <= rsp_d;
      pg_pin_q <= pg_pin_d;
    end
  end

  assign O_RSP_VALID         = rsp_q.valid;
  assign O_RSP_REFUSED       = rsp_q.refused;
  assign O_RSP_DATA          = rsp_q.data;
  assign O_POWER_GOOD_OUTPUT = pg_pin_q;
  assign O_WRITE_PROTECT     = cfg_q.write_protect_enable;
  assign O_ARA_ONLY          = cfg_q.ara & I_ALERT_ACTIVE;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);

  sequence s_taken(logic [7:0] code, logic w);
    I_CLK_EN && I_CMD_VALID && I_CMD_CODE == code && I_CMD_WRITE == w;
  endsequence

  in_status_set_a: assert property (I_CLK_EN && cond_q.vin_ov |=> stat_q.in_st[7])
    else $error("input ov not latched");
  temp_reserved_a: assert property (stat_q.temp_st[5:0] == 6'h00)
    else $error("temperature reserved bits set");
  bad_cmd_flag_a: assert property (I_CLK_EN && I_CMD_VALID && !known |=> stat_q.link_st[7])
    else $error("unknown command not flagged");
  sticky_hold_a: assert property (I_CLK_EN && stat_q.in_st[4] && in_clr[4] == 1'b0
                                   |=> stat_q.in_st[4])
    else $error("sticky bit dropped");
  rev_read_a: assert property (s_taken(`PMSC_CMD_REVISION, 1'b0)
                               |=> O_RSP_VALID && O_RSP_DATA == 16'h0042)
    else $error("revision byte wrong");
  wp_refuse_a: assert property (s_taken(`PMSC_CMD_VO_GAIN, 1'b1) ##0 cfg_q.write_protect_enable
                                |=> O_RSP_REFUSED && $stable(cfg_q.vo_gain))
    else $error("protected write taken");
  serial_lock_a: assert property (s_taken(`PMSC_CMD_SERIAL, 1'b1) ##0 cfg_q.write_protect_enable
                                  |=> O_RSP_REFUSED)
    else $error("protected serial write taken");
  fw_rev_read_a: assert property (s_taken(`PMSC_CMD_FW_REV, 1'b0)
                                  |=> O_RSP_DATA == FW_REV)
    else $error("firmware revision wrong");
  pec_flag_a: assert property (I_CLK_EN && I_PEC_ERROR |=> stat_q.link_st[5])
    else $error("packet check error not latched");
  overtemperature_warning_set_a: assert property (I_CLK_EN && cond_q.overtemperature_warning |=> stat_q.temp_st[6])
    else $error("overtemperature warning not latched");
  gain_range_a: assert property (cfg_q.vo_gain >= 16'h1999 && cfg_q.vo_gain <= 16'h2666)
    else $error("vout gain out of range");
  off_exp_a: assert property (cfg_q.vi_off[15:11] == $past(cfg_q.vi_off[15:11]) ||
                              cfg_q.vi_off[15:11] == 5'h1d)
    else $error("vin offset exponent wrong");
  // the pin flop takes the synced level and polarity seen at the enabled edge
  pg_pin_a: assert property (I_CLK_EN
                             |=> O_POWER_GOOD_OUTPUT == ($past(cond_q.power_good_output) ==
                                 $past(cfg_q.pg_pol)))
    else $error("power good pin polarity wrong");
endmodule : pmsc_regs
`default_nettype wire

// ===== verification/pmsc_host.sv
// host controller model issuing command reads and writes to the bank
`timescale 1ns/100ps
`default_nettype none
module pmsc_host (
  input  wire logic        i_clk,
  input  wire logic        i_rsp_valid,
  input  wire logic        i_rsp_refused,
  input  wire logic [15:0] i_rsp_data,
  output logic             o_valid,
  output logic             o_write,
  output logic [7:0]       o_code,
  output logic [15:0]      o_wdata,
  output logic [3:0]       o_idx
);
  // idle bus at time zero
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_code  = 8'h00;
    o_wdata = 16'h0000;
    o_idx   = 4'h0;
  end
  // offset words carry the given exponent in the top five bits, the mantissa below
  function automatic logic [15:0] off_word(input logic [4:0] e, input logic [10:0] m);
    return {e, m};
  endfunction : off_word
  // one command: driven after a falling edge, answer taken at the next falling edge, half a cycle after acceptance;
  // released code and data lines show the inverse so a stale value is never mistaken for a live one
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      input logic [3:0] x, output logic v, output logic r,
                      output logic [15:0] q);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_write = w;
    o_code  = c;
    o_wdata = d;
    o_idx   = x;
    @(negedge i_clk);
    v       = i_rsp_valid;
    r       = i_rsp_refused;
    q       = i_rsp_data;
    o_valid = 1'b0;
    o_code  = ~c;
    o_wdata = ~d;
  endtask : xfer
endmodule : pmsc_host
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the status and mfr command bank
`timescale 1ns/100ps
`default_nettype none
`include "pmsc_map.svh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module tb import pmsc_pkg::*;;
  localparam logic [5:0]  MOD_CODE = 6'h2d;   // arbitrary value
  localparam logic [15:0] FW       = 16'h3456;
  logic        clk, rst_n, en, pec, alert, v, w, rv, rr, ara, pgo, wp;
  logic [7:0]  cd;
  logic [15:0] wd, rq, tel;
  logic [3:0]  ix;
  pmsc_cond_t  cond;
  int          n_fail, check_count;
  logic [7:0]  gc [3] = '{`PMSC_CMD_VO_GAIN, `PMSC_CMD_VI_GAIN, `PMSC_CMD_IO_GAIN};
  pmsc_regs #(.MODULE_CODE(MOD_CODE), .FW_REV(FW)) DUT (
    .I_SYS_CLK(clk), .I_ARST_N(rst_n), .I_CLK_EN(en), .I_CMD_VALID(v),
    .I_CMD_WRITE(w), .I_CMD_CODE(cd), .I_CMD_WDATA(wd), .I_CMD_BYTE_IDX(ix),
    .I_PEC_ERROR(pec), .I_VIN_OV(cond.vin_ov), .I_VIN_UV(cond.vin_uv),
    .I_VIN_LOW_OFF(cond.vin_low_off), .I_OVERTEMPERATURE_FAULT(cond.overtemperature_fault),
    .I_OVERTEMPERATURE_WARNING(cond.overtemperature_warning), .I_POWER_IS_GOOD(cond.power_good_output), .I_ALERT_ACTIVE(alert),
    .I_VIN_READING(tel), .I_VOUT_READING(~tel), .I_IOUT_READING(tel ^ 16'h00ff),
    .I_TEMP_READING({tel[7:0], tel[15:8]}), .O_RSP_VALID(rv), .O_RSP_REFUSED(rr),
    .O_RSP_DATA(rq), .O_ARA_ONLY(ara), .O_POWER_GOOD_OUTPUT(pgo), .O_WRITE_PROTECT(wp));
  pmsc_host HOST (.i_clk(clk), .i_rsp_valid(rv), .i_rsp_refused(rr), .i_rsp_data(rq),
    .o_valid(v), .o_write(w), .o_code(cd), .o_wdata(wd), .o_idx(ix));
  // ****************************************
  // shared command tasks
  // ****************************************
  task automatic cmd(input logic is_wr, input logic [7:0] c, input logic [15:0] d,
                     input logic [3:0] x, input logic er, input logic [15:0] ed);
    logic        gv, gr;
    logic [15:0] gq;
    HOST.xfer(is_wr, c, d, x, gv, gr, gq);
    `CHK("rsp valid", 1'b1, gv)
    `CHK("refused", er, gr)
    `CHK("rsp data", ed, gq)
  endtask : cmd
  task automatic rd(input logic [7:0] c, input logic [15:0] ed);
    cmd(1'b0, c, 16'h0000, 4'h0, 1'b0, ed);
  endtask : rd
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic er);
    cmd(1'b1, c, d, 4'h0, er, 16'h0000);
  endtask : wr
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd(`PMSC_CMD_REVISION, 16'h0042);
    rd(`PMSC_CMD_MOD_TYPE, {8'h00, MOD_CODE, 2'b10});
    rd(`PMSC_CMD_VO_GAIN, 16'h2000);
    rd(`PMSC_CMD_VI_GAIN, 16'h2000);
    rd(`PMSC_CMD_FW_REV, FW);
    rd(`PMSC_CMD_ARA_CFG, 16'h0000);
    rd(`PMSC_CMD_PG_POL, 16'h0001);
    rd(`PMSC_CMD_IN_STATUS, 16'h0000);
    rd(`PMSC_CMD_RD_VIN, 16'h1234);
    rd(`PMSC_CMD_RD_VOUT, 16'hedcb);
    rd(`PMSC_CMD_RD_IOUT, 16'h12cb);
    rd(`PMSC_CMD_RD_TEMP, 16'h3412);
    `CHK("write protect", 1'b1, wp)
  endtask : t_reset
  // protected write refused, then unlock and walk the gain limits
  task automatic t_protect;
    wr(`PMSC_CMD_VO_GAIN, 16'h2222, 1'b1);
    rd(`PMSC_CMD_VO_GAIN, 16'h2000);
    wr(`PMSC_CMD_MOD_TYPE, 16'hfffd, 1'b0);
    `CHK("write protect", 1'b0, wp)
    rd(`PMSC_CMD_MOD_TYPE, {8'h00, MOD_CODE, 2'b00});
    for (int i = 0; i < 3; i++) begin
      wr(gc[i], 16'h1998, 1'b1);
      wr(gc[i], 16'h2667, 1'b1);
      wr(gc[i], 16'h1999, 1'b0);
      rd(gc[i], 16'h1999);
      wr(gc[i], 16'h2666, 1'b0);
      rd(gc[i], 16'h2666);
    end
  endtask : t_protect
  // exponent -12 is 5'h14 and -3 is 5'h1d in the top five bits
  task automatic t_offset;
    wr(`PMSC_CMD_VO_OFF, HOST.off_word(5'h14, 11'h123), 1'b0);
    rd(`PMSC_CMD_VO_OFF, 16'ha123);
    wr(`PMSC_CMD_VO_OFF, 16'he800, 1'b1);
    wr(`PMSC_CMD_VI_OFF, HOST.off_word(5'h1d, 11'h7ff), 1'b0);
    rd(`PMSC_CMD_VI_OFF, 16'hefff);
    wr(`PMSC_CMD_VI_OFF, 16'ha001, 1'b1);
    wr(`PMSC_CMD_IO_OFF, HOST.off_word(5'h1d, 11'h00f), 1'b0);
    rd(`PMSC_CMD_IO_OFF, 16'he80f);
    wr(`PMSC_CMD_IO_OFF, 16'ha001, 1'b1);
  endtask : t_offset
  // end bytes of the block, one past the end, then lock again
  task automatic t_serial;
    cmd(1'b1, `PMSC_CMD_SERIAL, 16'h00a5, 4'h0, 1'b0, 16'h0000);
    cmd(1'b1, `PMSC_CMD_SERIAL, 16'h005c, 4'hb, 1'b0, 16'h0000);
    cmd(1'b0, `PMSC_CMD_SERIAL, 16'h0000, 4'h0, 1'b0, 16'h00a5);
    cmd(1'b0, `PMSC_CMD_SERIAL, 16'h0000, 4'hb, 1'b0, 16'h005c);
    cmd(1'b1, `PMSC_CMD_SERIAL, 16'h0011, 4'hc, 1'b1, 16'h0000);
    cmd(1'b0, `PMSC_CMD_SERIAL, 16'h0000, 4'hc, 1'b1, 16'h0000);
    wr(`PMSC_CMD_MOD_TYPE, 16'h0002, 1'b0);
    cmd(1'b1, `PMSC_CMD_SERIAL, 16'h0077, 4'h0, 1'b1, 16'h0000);
    cmd(1'b0, `PMSC_CMD_SERIAL, 16'h0000, 4'h0, 1'b0, 16'h00a5);
    wr(`PMSC_CMD_IO_OFF, 16'he801, 1'b1);
  endtask : t_serial
  task automatic t_status;
    wr(`PMSC_CMD_LINK_STATUS, 16'h00ff, 1'b0);
    rd(`PMSC_CMD_LINK_STATUS, 16'h0000);
    cmd(1'b0, 8'h01, 16'h0000, 4'h0, 1'b1, 16'h0000);
    wr(`PMSC_CMD_RD_VIN, 16'h0000, 1'b1);
    wr(`PMSC_CMD_FW_REV, 16'h0000, 1'b1);
    rd(`PMSC_CMD_FW_REV, FW);
    wr(`PMSC_CMD_VO_GAIN, 16'h0001, 1'b1);
    @(negedge clk) pec = 1'b1;
    @(negedge clk) pec = 1'b0;
    rd(`PMSC_CMD_LINK_STATUS, 16'h00e0);
    wr(`PMSC_CMD_LINK_STATUS, 16'h0080, 1'b0);
    rd(`PMSC_CMD_LINK_STATUS, 16'h0060);
    @(negedge clk) cond = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    repeat (4) @(negedge clk);
    cond = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    rd(`PMSC_CMD_IN_STATUS, 16'h0098);
    rd(`PMSC_CMD_TEMP_STATUS, 16'h00c0);
    wr(`PMSC_CMD_IN_STATUS, 16'h00ff, 1'b0);
    rd(`PMSC_CMD_IN_STATUS, 16'h0000);
  endtask : t_status
  task automatic t_pins;
    `CHK("power good pin", 1'b1, pgo)
    wr(`PMSC_CMD_PG_POL, 16'h00fe, 1'b0);
    rd(`PMSC_CMD_PG_POL, 16'h0000);
    `CHK("power good pin", 1'b0, pgo)
    // a low enable must freeze the synchroniser and the pin flop
    en = 1'b0;
    cond.power_good_output = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("power good pin", 1'b0, pgo)
    en = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("power good pin", 1'b1, pgo)
    alert = 1'b1;
    #1 `CHK("ara only", 1'b0, ara)
    wr(`PMSC_CMD_ARA_CFG, 16'h00f0, 1'b0);
    rd(`PMSC_CMD_ARA_CFG, 16'h0010);
    `CHK("ara only", 1'b1, ara)
    @(negedge clk) alert = 1'b0;
    #1 `CHK("ara only", 1'b0, ara)
  endtask : t_pins
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // watchdog, far beyond the fewer than two hundred cycles the run needs
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
  // main sequence
  initial begin
    n_fail = 0;
    check_count = 0;
    rst_n = 1'b0;
    en = 1'b1;
    pec = 1'b0;
    alert = 1'b0;
    tel = 16'h1234;
    cond = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_protect();
    t_offset();
    t_serial();
    t_status();
    t_pins();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
